// >>> rsd_cfg.svh
// Resync selector constants: layout, pattern bits, sizes.
// Assumes inclusion by bare name.
`ifndef RSD_CFG_SVH
`define RSD_CFG_SVH

// ---------------------------------------------------------------
// Field layout
// ---------------------------------------------------------------
`define RSD_FIELD_BITS 24
`define RSD_RS_BITS 20
`define RSD_INV_BITS 4

// ---------------------------------------------------------------
// Fixed part: filler, inverted bit, x slot
// ---------------------------------------------------------------
`define RSD_RS_FILLER 20'h10302
`define RSD_RS_INV_MASK 20'h00200
`define RSD_RS_X_POS 18

// ---------------------------------------------------------------
// Sector shape and sizes
// ---------------------------------------------------------------
`define RSD_NUM_BLOCKS 59
`define RSD_BLK_BITS 1024
`define RSD_SUM_W 16
`define RSD_START_LEVEL 1'b0

`endif

// >>> rsd_pkg.sv
// Types shared by the resync selector modules.
// Assumes nothing of its surroundings.
`default_nettype none

package rsd_pkg;

  // ---------------------------------------------------------------
  // Sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_HEAD,
    ST_HEAD_RS,
    ST_P0,
    ST_FILL,
    ST_RS_SUM,
    ST_DECIDE,
    ST_EMIT_INV,
    ST_EMIT_BLK,
    ST_EMIT_RS
  } rsd_state_e;

  // Sum and end level of the selectable bits
  typedef struct packed {
    logic lend;
    logic signed [3:0] sum;
  } rsd_inv_s;

endpackage

`default_nettype wire

// >>> rsd_level_sum.sv
// Level-form running sum: ONE toggles the level, each bit adds +1/-1.
// Assumes step and clr are on clk_sys; clr wins.
`include "rsd_cfg.svh"
`default_nettype none

module rsd_level_sum #(
  parameter int SUM_W = `RSD_SUM_W
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  // Control
  input wire logic clr,
  input wire logic start_level,
  input wire logic step,
  input wire logic chan_bit,
  // Result
  output logic level,
  output logic signed [SUM_W-1:0] sum
);

  typedef struct packed {
    logic level;
    logic signed [SUM_W-1:0] sum;
  } rsd_acc_s;

  localparam logic signed [SUM_W-1:0] ONE = 1;

  generate
    if (SUM_W < 8) begin : g_chk
      $error("rsd_level_sum: SUM_W too small");
    end
  endgenerate

  rsd_acc_s acc_reg;
  rsd_acc_s acc_next;

  // ONE toggles the level; level counts +1 or -1
  always_comb begin
    acc_next = acc_reg;
    if (clr) begin
      acc_next.level = start_level;
      acc_next.sum = '0;
    end else if (step) begin
      acc_next.level = acc_reg.level ^ chan_bit;
      acc_next.sum = acc_next.level ? acc_reg.sum + ONE : acc_reg.sum - ONE;
    end
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      acc_reg <= '0;
    end else if (ce) begin
      acc_reg <= acc_next;
    end
  end

  assign level = acc_reg.level;
  assign sum = acc_reg.sum;

endmodule

`default_nettype wire

// >>> rsd_block_buf.sv
// One-block bit buffer: filled once, read out in order.
// Assumes at most DEPTH bits per block; clr rewinds both pointers.
`include "rsd_cfg.svh"
`default_nettype none

module rsd_block_buf #(
  parameter int DEPTH = `RSD_BLK_BITS,
  parameter int AW = $clog2(DEPTH)
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  // Write side
  input wire logic clr,
  input wire logic wr_en,
  input wire logic wr_bit,
  output logic full,
  // Read side
  input wire logic rd_en,
  output logic rd_bit,
  output logic rd_last,
  output logic empty
);

  typedef struct packed {
    logic [DEPTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } rsd_buf_s;

  localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW:0] ONE = 1;

  generate
    if (DEPTH < 2 || (1 << AW) < DEPTH) begin : g_chk
      $error("rsd_block_buf: DEPTH and AW do not fit");
    end
  endgenerate

  rsd_buf_s buf_reg;
  rsd_buf_s buf_next;

  // Pointer and storage update; clr keeps stored bits
  always_comb begin
    buf_next = buf_reg;
    if (clr) begin
      buf_next.wr_ptr = '0;
      buf_next.rd_ptr = '0;
    end else begin
      if (wr_en && !full) begin
        buf_next.mem[buf_reg.wr_ptr[AW-1:0]] = wr_bit;
        buf_next.wr_ptr = buf_reg.wr_ptr + ONE;
      end
      if (rd_en && !empty) begin
        buf_next.rd_ptr = buf_reg.rd_ptr + ONE;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      buf_reg <= '0;
    end else if (ce) begin
      buf_reg <= buf_next;
    end
  end

  assign full = (buf_reg.wr_ptr == FULL_CNT);
  assign empty = (buf_reg.rd_ptr == buf_reg.wr_ptr);
  assign rd_last = ((buf_reg.rd_ptr + ONE) == buf_reg.wr_ptr);
  assign rd_bit = buf_reg.mem[buf_reg.rd_ptr[AW-1:0]];

endmodule

`default_nettype wire

// >>> rsd_resync_selector.sv
// Resync insertion with running-sum variant choice for one sector data field.
// Assumes a modulator on clk_sys sends head (preamble, sync, block 0) and block
// channel bits, each block's first information bit, and the x bit that a flush
// with two ZERO information bits gives.
//
// How it works
// - Each resync field is exactly 24 channel bits.
// - Field holds seven ZEROs, ONE, six ZEROs.
// - Irregular run visible on either edge kind.
// - Two variants with odd and even ONE counts.
// - Select bit ZERO gives variant 1, ONE variant 2.
// - Fixed part then selectable part 000y or 100y.
// - First bits from flushing data with ZERO ZERO.
// - One filler bit inverted to make the run.
// - Last three bits from ZERO, ZERO ONE, next bit.
// - Sum runs on level form, ONE toggles level.
// - Level ZERO counts -1, level ONE counts +1.
// - Segment levels continue from preceding level.
// - Head, block 0, then 59 resync-block pairs.
// - Start sum after head (code sums the head and first fixed part too); pick smaller per step.
// - Last step has no trailing fixed part.
// - Equal magnitudes choose variant 1.
`include "rsd_cfg.svh"
`default_nettype none

module rsd_resync_selector #(
  parameter int NUM_BLOCKS = `RSD_NUM_BLOCKS,
  parameter int BLK_BITS = `RSD_BLK_BITS,
  parameter int SUM_W = `RSD_SUM_W
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  // Sector control
  input wire logic sector_start,
  output logic busy,
  output logic sector_done,
  output logic sel_variant,
  // Coded input stream from the modulator
  input wire logic in_valid,
  output logic in_ready,
  input wire logic in_bit,
  input wire logic in_last,
  input wire logic in_first_info,
  input wire logic in_flush_x,
  // Coded output stream to the write channel
  output logic out_valid,
  input wire logic out_ready,
  output logic out_bit,
  output logic out_resync
);

  // ---------------------------------------------------------------
  // Sizes and checks
  // ---------------------------------------------------------------
  localparam int IW = $clog2(NUM_BLOCKS + 1);
  localparam logic [IW-1:0] LAST_IDX = IW'(NUM_BLOCKS);
  localparam logic [IW-1:0] IDX_ONE = 1;
  localparam logic [4:0] RS_LAST = 5'(`RSD_RS_BITS - 1);
  localparam logic [4:0] INV_LAST = 5'(`RSD_INV_BITS - 1);
  localparam logic [4:0] CNT_ONE = 1;

  generate
    if (`RSD_RS_BITS + `RSD_INV_BITS != `RSD_FIELD_BITS) begin : g_chk_len
      $error("rsd_resync_selector: field parts do not add up");
    end
    if (NUM_BLOCKS < 1 || BLK_BITS < 2 || SUM_W < 8) begin : g_chk_par
      $error("rsd_resync_selector: bad parameter");
    end
  endgenerate

  // ---------------------------------------------------------------
  // Pattern helpers
  // ---------------------------------------------------------------

  // Bit i of the fixed part: filler with one bit flipped, x in its slot
  function automatic logic rs_bit(input logic [4:0] i, input logic x);
    logic [`RSD_RS_BITS-1:0] v;
    v = `RSD_RS_FILLER ^ `RSD_RS_INV_MASK;
    v[`RSD_RS_X_POS] = x;
    rs_bit = v[RS_LAST - i];
  endfunction

  // Bit i of the selectable part: z, then ZERO ZERO, then y
  function automatic logic inv_bit(input logic [4:0] i, input logic z, input logic y);
    inv_bit = 1'b0;
    if (i == 5'h00) begin
      inv_bit = z;
    end else if (i == INV_LAST) begin
      inv_bit = y;
    end
  endfunction

  // Level-form sum and end level of the selectable part
  function automatic rsd_pkg::rsd_inv_s inv_eval(input logic lvl, input logic z,
                                                  input logic y);
    rsd_pkg::rsd_inv_s e;
    logic l;
    e = '0;
    l = lvl;
    for (int i = 0; i < `RSD_INV_BITS; i++) begin
      l = l ^ inv_bit(5'(i), z, y);
      e.sum = l ? e.sum + 4'sh1 : e.sum - 4'sh1;
    end
    e.lend = l;
    inv_eval = e;
  endfunction

  // Magnitude of a running sum
  function automatic logic [SUM_W-1:0] mag(input logic signed [SUM_W-1:0] v);
    mag = (v < 0) ? -v : v;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    rsd_pkg::rsd_state_e st;
    logic signed [SUM_W-1:0] p;
    logic lvl;
    logic [IW-1:0] idx;
    logic [4:0] cnt;
    logic mid;
    logic x_next;
    logic y_next;
    logic z;
    logic ov;
    logic ob;
    logic ors;
    logic done;
  } rsd_sel_s;

  rsd_sel_s sel_reg;
  rsd_sel_s sel_next;

  // Accumulator and buffer controls
  logic acc_clr;
  logic acc_step;
  logic acc_bit;
  logic acc_level;
  logic signed [SUM_W-1:0] acc_sum;
  logic buf_clr;
  logic buf_wr;
  logic buf_rd;
  logic buf_full;
  logic buf_empty;
  logic buf_last;
  logic buf_bit;
  logic in_ready_c;
  logic out_free;
  rsd_pkg::rsd_inv_s e0;
  rsd_pkg::rsd_inv_s e1;
  logic signed [SUM_W-1:0] c0;
  logic signed [SUM_W-1:0] c1;

  // ---------------------------------------------------------------
  // Candidate sums
  // ---------------------------------------------------------------

  // The block and the next fixed part are summed from level ZERO; a start at
  // level ONE mirrors every level, so that sum only changes sign
  always_comb begin
    e0 = inv_eval(sel_reg.lvl, 1'b0, sel_reg.y_next);
    e1 = inv_eval(sel_reg.lvl, 1'b1, sel_reg.y_next);
    c0 = sel_reg.p + SUM_W'(e0.sum) + (e0.lend ? -acc_sum : acc_sum);
    c1 = sel_reg.p + SUM_W'(e1.sum) + (e1.lend ? -acc_sum : acc_sum);
  end

  // ---------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------

  // One output register, reloaded when empty or being taken
  always_comb begin
    sel_next = sel_reg;
    sel_next.done = 1'b0;
    acc_clr = 1'b0;
    acc_step = 1'b0;
    acc_bit = 1'b0;
    buf_clr = 1'b0;
    buf_wr = 1'b0;
    buf_rd = 1'b0;
    in_ready_c = 1'b0;
    out_free = !sel_reg.ov || out_ready;
    if (sel_reg.ov && out_ready) begin
      sel_next.ov = 1'b0;
    end
    case (sel_reg.st)
      rsd_pkg::ST_IDLE: begin
        if (sector_start) begin
          acc_clr = 1'b1;
          sel_next.p = '0;
          sel_next.idx = '0;
          sel_next.st = rsd_pkg::ST_HEAD;
        end
      end
      // Head passes through while its sum builds
      rsd_pkg::ST_HEAD: begin
        in_ready_c = out_free;
        if (in_valid && out_free) begin
          sel_next.ov = 1'b1;
          sel_next.ob = in_bit;
          sel_next.ors = 1'b0;
          acc_step = 1'b1;
          acc_bit = in_bit;
          if (in_last) begin
            sel_next.x_next = in_flush_x;
            sel_next.cnt = '0;
            sel_next.st = rsd_pkg::ST_HEAD_RS;
          end
        end
      end
      rsd_pkg::ST_HEAD_RS: begin
        if (out_free) begin
          sel_next.ov = 1'b1;
          sel_next.ob = rs_bit(sel_reg.cnt, sel_reg.x_next);
          sel_next.ors = 1'b1;
          acc_step = 1'b1;
          acc_bit = rs_bit(sel_reg.cnt, sel_reg.x_next);
          sel_next.cnt = sel_reg.cnt + CNT_ONE;
          if (sel_reg.cnt == RS_LAST) begin
            sel_next.st = rsd_pkg::ST_P0;
          end
        end
      end
      // Head and first fixed part give the starting sum and level
      rsd_pkg::ST_P0: begin
        sel_next.p = acc_sum;
        sel_next.lvl = acc_level;
        acc_clr = 1'b1;
        buf_clr = 1'b1;
        sel_next.idx = sel_reg.idx + IDX_ONE;
        sel_next.mid = 1'b0;
        sel_next.st = rsd_pkg::ST_FILL;
      end
      // A block is held until its selectable bits are known
      rsd_pkg::ST_FILL: begin
        in_ready_c = !buf_full;
        if (in_valid && !buf_full) begin
          buf_wr = 1'b1;
          acc_step = 1'b1;
          acc_bit = in_bit;
          sel_next.mid = 1'b1;
          if (!sel_reg.mid) begin
            sel_next.y_next = ~in_first_info;
          end
          if (in_last) begin
            sel_next.x_next = in_flush_x;
            sel_next.cnt = '0;
            if (sel_reg.idx == LAST_IDX) begin
              sel_next.st = rsd_pkg::ST_DECIDE;
            end else begin
              sel_next.st = rsd_pkg::ST_RS_SUM;
            end
          end
        end
      end
      // Next fixed part counted ahead of emission, without output
      rsd_pkg::ST_RS_SUM: begin
        acc_step = 1'b1;
        acc_bit = rs_bit(sel_reg.cnt, sel_reg.x_next);
        sel_next.cnt = sel_reg.cnt + CNT_ONE;
        if (sel_reg.cnt == RS_LAST) begin
          sel_next.st = rsd_pkg::ST_DECIDE;
        end
      end
      // Variant 2 only when strictly smaller
      rsd_pkg::ST_DECIDE: begin
        if (mag(c1) < mag(c0)) begin
          sel_next.z = 1'b1;
          sel_next.p = c1;
          sel_next.lvl = e1.lend ^ acc_level;
        end else begin
          sel_next.z = 1'b0;
          sel_next.p = c0;
          sel_next.lvl = e0.lend ^ acc_level;
        end
        sel_next.cnt = '0;
        sel_next.st = rsd_pkg::ST_EMIT_INV;
      end
      rsd_pkg::ST_EMIT_INV: begin
        if (out_free) begin
          sel_next.ov = 1'b1;
          sel_next.ob = inv_bit(sel_reg.cnt, sel_reg.z, sel_reg.y_next);
          sel_next.ors = 1'b1;
          sel_next.cnt = sel_reg.cnt + CNT_ONE;
          if (sel_reg.cnt == INV_LAST) begin
            sel_next.st = rsd_pkg::ST_EMIT_BLK;
          end
        end
      end
      rsd_pkg::ST_EMIT_BLK: begin
        if (out_free && !buf_empty) begin
          sel_next.ov = 1'b1;
          sel_next.ob = buf_bit;
          sel_next.ors = 1'b0;
          buf_rd = 1'b1;
          if (buf_last) begin
            sel_next.cnt = '0;
            if (sel_reg.idx == LAST_IDX) begin
              sel_next.done = 1'b1;
              sel_next.st = rsd_pkg::ST_IDLE;
            end else begin
              sel_next.st = rsd_pkg::ST_EMIT_RS;
            end
          end
        end
      end
      // Fixed part goes out, then the next block fills
      rsd_pkg::ST_EMIT_RS: begin
        if (out_free) begin
          sel_next.ov = 1'b1;
          sel_next.ob = rs_bit(sel_reg.cnt, sel_reg.x_next);
          sel_next.ors = 1'b1;
          sel_next.cnt = sel_reg.cnt + CNT_ONE;
          if (sel_reg.cnt == RS_LAST) begin
            acc_clr = 1'b1;
            buf_clr = 1'b1;
            sel_next.idx = sel_reg.idx + IDX_ONE;
            sel_next.mid = 1'b0;
            sel_next.st = rsd_pkg::ST_FILL;
          end
        end
      end
      default: begin
        sel_next.st = rsd_pkg::ST_IDLE;
      end
    endcase
  end

  // State register, frozen while ce is low
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sel_reg <= '0;
    end else if (ce) begin
      sel_reg <= sel_next;
    end
  end

  // ---------------------------------------------------------------
  // Sub-blocks
  // ---------------------------------------------------------------

  // Segment sums restart at level ZERO; the start level is applied later
  rsd_level_sum #(
    .SUM_W(SUM_W)
  ) u_acc (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .clr(acc_clr),
    .start_level(`RSD_START_LEVEL),
    .step(acc_step),
    .chan_bit(acc_bit),
    .level(acc_level),
    .sum(acc_sum)
  );

  rsd_block_buf #(
    .DEPTH(BLK_BITS)
  ) u_buf (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .ce(ce),
    .clr(buf_clr),
    .wr_en(buf_wr),
    .wr_bit(in_bit),
    .full(buf_full),
    .rd_en(buf_rd),
    .rd_bit(buf_bit),
    .rd_last(buf_last),
    .empty(buf_empty)
  );

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------

  // Handshakes gated by ce: nothing moves while frozen
  assign in_ready = ce && in_ready_c;
  assign out_valid = ce && sel_reg.ov;
  assign out_bit = sel_reg.ob;
  assign out_resync = sel_reg.ors;
  assign busy = (sel_reg.st != rsd_pkg::ST_IDLE);
  assign sector_done = sel_reg.done;
  assign sel_variant = sel_reg.z;

endmodule

`default_nettype wire

// >>> rsd_resync_monitor.sv
// Checker: field shape, select bits, handshakes.
// Assumes binding to the selector; sees only its ports.
`default_nettype none

module rsd_resync_monitor (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic ce,
  // Sector control
  input wire logic sector_start,
  input wire logic busy,
  input wire logic sector_done,
  input wire logic sel_variant,
  // Input stream
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic in_bit,
  input wire logic in_last,
  input wire logic in_first_info,
  input wire logic in_flush_x,
  // Output stream
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_bit,
  input wire logic out_resync
);
  // --------
  // Field tracking
  // --------
  // Known field bits by index; x, z, y checked apart
  localparam logic [23:0] FIX_MASK = 24'h6ffffd;
  localparam logic [23:0] FIX_VAL = 24'h040808;
  logic xfer, acc, x_reg, fi_reg, first_reg, head_reg;
  logic [4:0] cnt_reg;
  assign xfer = out_valid && out_ready;
  assign acc = ce && in_valid && in_ready;
  // Count field bits; keep x and the next block's first info bit
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 5'h00;
      x_reg <= 1'b0;
      fi_reg <= 1'b0;
      first_reg <= 1'b0;
      head_reg <= 1'b0;
    end else begin
      if (xfer) cnt_reg <= out_resync ? cnt_reg + 5'h01 : 5'h00;
      if (sector_start && !busy && ce) head_reg <= 1'b1;
      if (acc && in_last) head_reg <= 1'b0;
      if (acc && in_last) x_reg <= in_flush_x;
      if (acc && first_reg && !head_reg) fi_reg <= in_first_info;
      if (acc) first_reg <= in_last;
    end
  end

  // --------
  // Properties
  // --------
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!arst_n);
  sequence s_stall;
    out_valid && !out_ready ##1 ce;
  endsequence
  // Head end excluded: a fixed part follows at once
  sequence s_blk_end;
    acc && in_last && !head_reg;
  endsequence
  a_field_len: assert property (xfer && !out_resync |-> cnt_reg == 5'h00 || cnt_reg == 5'h18)
    else $error("field length wrong");
  a_fixed_bits: assert property (xfer && out_resync && cnt_reg < 5'h18 && FIX_MASK[cnt_reg]
    |-> out_bit == FIX_VAL[cnt_reg]) else $error("fixed bit wrong");
  a_x_bit: assert property (xfer && out_resync && cnt_reg == 5'h01 |-> out_bit == x_reg)
    else $error("x bit wrong");
  a_z_bit: assert property (xfer && out_resync && cnt_reg == 5'h14 |-> out_bit == sel_variant)
    else $error("z bit wrong");
  a_y_bit: assert property (xfer && out_resync && cnt_reg == 5'h17 |-> out_bit == !fi_reg)
    else $error("y bit wrong");
  a_stall_hold: assert property (s_stall |-> out_valid && $stable(out_bit) && $stable(out_resync))
    else $error("stall not held");
  a_done_pulse: assert property (sector_done |=> !sector_done)
    else $error("done too long");
  a_start_busy: assert property (sector_start && !busy && ce |=> busy)
    else $error("start ignored");
  a_no_early: assert property (s_blk_end |=> (!out_valid || out_resync) [*5])
    else $error("data too early");
endmodule

bind rsd_resync_selector rsd_resync_monitor i_rsd_resync_monitor (
  .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .sector_start(sector_start), .busy(busy),
  .sector_done(sector_done), .sel_variant(sel_variant), .in_valid(in_valid),
  .in_ready(in_ready), .in_bit(in_bit), .in_last(in_last), .in_first_info(in_first_info),
  .in_flush_x(in_flush_x), .out_valid(out_valid), .out_ready(out_ready), .out_bit(out_bit),
  .out_resync(out_resync));

`default_nettype wire

// >>> rsd_write_sink.sv
// Write channel model: paces the stream, records each bit.
// Assumes the bench clears the record between sectors.
`default_nettype none

module rsd_write_sink (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Pacing: low takes every bit, high takes one in three
  input wire logic slow,
  // Coded stream
  input wire logic out_valid,
  input wire logic out_bit,
  input wire logic out_resync,
  output logic out_ready
);
  logic [1:0] ph_reg;
  logic [1:0] got_q[$];
  // Slow pacing stalls inside fields and blocks alike
  always @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      ph_reg <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      ph_reg <= (ph_reg == 2'h2) ? 2'h0 : ph_reg + 2'h1;
      out_ready <= !slow || (ph_reg == 2'h2);
      if (out_valid && out_ready) got_q.push_back({out_resync, out_bit});
    end
  end
endmodule

`default_nettype wire

// >>> rsd_resync_selector_test.sv
// Bench: whole sectors through a pacing write sink.
// Assumes three blocks of at most 16 bits each.
`default_nettype none

module rsd_resync_selector_test;
  timeunit 1ns;
  timeprecision 1ps;
  // --------
  // Rows and expected stream
  // --------
  localparam int NB = 3;
  // Fixed part in send order, x slot shown as ZERO
  localparam logic [19:0] FIX = 20'h10102;
  typedef struct packed {
    logic [7:0] head;
    logic [47:0] blk;
    logic [2:0] fi;
    logic [2:0] x;
    logic [4:0] len;
    logic slow;
  } rsd_row_s;
  // Row 0 head and fixed part sum to zero, forcing a first-step tie
  rsd_row_s rows [4] = '{
    '{8'h88, 48'h1248_4821_0a50, 3'h2, 3'h0, 5'h10, 1'b0},
    '{8'h00, 48'h0000_0000_0000, 3'h7, 3'h5, 5'h10, 1'b1},
    '{8'h24, 48'h8421_1111_9249, 3'h4, 3'h2, 5'h05, 1'b0},
    '{8'hff, 48'h4444_2222_aaaa, 3'h1, 3'h7, 5'h10, 1'b1}};
  logic clk_sys, arst_n, ce, sector_start, busy, sector_done, sel_variant, slow, last_z;
  logic in_valid, in_ready, in_bit, in_last, in_first_info, in_flush_x;
  logic out_valid, out_ready, out_bit, out_resync;
  logic [1:0] exp_q[$];
  int mismatches = 0, comparisons = 0, dones = 0;

  rsd_resync_selector #(.NUM_BLOCKS(NB), .BLK_BITS(16), .SUM_W(16)) i_rsd_resync_selector (
    .clk_sys(clk_sys), .arst_n(arst_n), .ce(ce), .sector_start(sector_start), .busy(busy),
    .sector_done(sector_done), .sel_variant(sel_variant), .in_valid(in_valid),
    .in_ready(in_ready), .in_bit(in_bit), .in_last(in_last), .in_first_info(in_first_info),
    .in_flush_x(in_flush_x), .out_valid(out_valid), .out_ready(out_ready), .out_bit(out_bit),
    .out_resync(out_resync));
  rsd_write_sink i_rsd_write_sink (.clk_sys(clk_sys), .arst_n(arst_n), .slow(slow),
    .out_valid(out_valid), .out_bit(out_bit), .out_resync(out_resync), .out_ready(out_ready));

  // Clock, done counter and watchdog
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (sector_done === 1'b1) dones++;
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    summarize();
  end

  // --------
  // Reference model
  // --------
  function automatic logic fixb(input int i, input logic x);
    return (i == 1) ? x : FIX[19-i];
  endfunction
  // ONE toggles the level; level adds +1 or -1
  function automatic void put_exp(input logic v, input logic rs, input logic keep,
                                  inout int l, inout int p);
    if (v) l = 1 - l;
    p += (l != 0) ? 1 : -1;
    if (keep) exp_q.push_back({rs, v});
  endfunction
  // Selectable part, block b, then a fixed part unless b is last
  function automatic void seg(input rsd_row_s r, input int b, input logic z, input logic keep,
                              inout int l, inout int p);
    logic [3:0] sp;
    sp = {z, 2'b00, ~r.fi[b-1]};
    for (int i = 0; i < 4; i++) put_exp(sp[3-i], 1'b1, keep, l, p);
    for (int i = 0; i < r.len; i++) put_exp(r.blk[63-16*b-i], 1'b0, keep, l, p);
    if (b < NB) for (int i = 0; i < 20; i++) put_exp(fixb(i, r.x[b]), 1'b1, keep, l, p);
  endfunction
  task automatic model(input rsd_row_s r);
    int l, p, la, pa, lb, pb;
    exp_q.delete();
    l = 0;
    p = 0;
    for (int i = 0; i < 8; i++) put_exp(r.head[7-i], 1'b0, 1'b1, l, p);
    for (int i = 0; i < 20; i++) put_exp(fixb(i, r.x[0]), 1'b1, 1'b1, l, p);
    for (int b = 1; b <= NB; b++) begin
      la = l;
      pa = p;
      lb = l;
      pb = p;
      seg(r, b, 1'b0, 1'b0, la, pa);
      seg(r, b, 1'b1, 1'b0, lb, pb);
      // Ties keep variant 1
      last_z = ((pb < 0 ? -pb : pb) < (pa < 0 ? -pa : pa));
      seg(r, b, last_z, 1'b1, l, p);
    end
  endtask

  // --------
  // Drivers and compares
  // --------
  // Ready is judged mid-cycle; a hang is left to the watchdog
  task automatic put(input logic b, input logic l, input logic f, input logic x);
    logic ok;
    in_valid = 1'b1;
    in_bit = b;
    in_last = l;
    in_first_info = f;
    in_flush_x = x;
    do begin
      @(negedge clk_sys);
      ok = (in_ready === 1'b1);
      @(posedge clk_sys);
      #1;
    end while (!ok);
  endtask
  task automatic chk_v(input string what, input logic [1:0] exp, input logic [1:0] got);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_n(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      mismatches++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic run_row(input rsd_row_s r);
    int d0;
    model(r);
    d0 = dones;
    slow = r.slow;
    i_rsd_write_sink.got_q.delete();
    sector_start = 1'b1;
    @(posedge clk_sys);
    #1;
    sector_start = 1'b0;
    for (int i = 0; i < 8; i++) put(r.head[7-i], i == 7, 1'b0, r.x[0]);
    for (int b = 1; b <= NB; b++) begin
      for (int i = 0; i < r.len; i++) put(r.blk[63-16*b-i], i == r.len - 1, r.fi[b-1], r.x[b%3]);
    end
    in_valid = 1'b0;
    while (busy !== 1'b0 || out_valid !== 1'b0) begin
      @(posedge clk_sys);
      #1;
    end
    chk_n("stream length", exp_q.size(), i_rsd_write_sink.got_q.size());
    foreach (exp_q[i]) chk_v("stream bit", exp_q[i], i_rsd_write_sink.got_q[i]);
    chk_v("variant", {1'b0, last_z}, {1'b0, sel_variant});
    chk_n("done pulses", d0 + 1, dones);
    $display("sector done, %0d checks", comparisons);
  endtask
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // --------
  // Main sequence
  // --------
  initial begin
    arst_n = 1'b0;
    ce = 1'b1;
    sector_start = 1'b0;
    in_valid = 1'b0;
    in_bit = 1'b0;
    in_last = 1'b0;
    in_first_info = 1'b0;
    in_flush_x = 1'b0;
    slow = 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    chk_v("reset busy/valid", 2'h0, {busy, out_valid});
    chk_v("reset ready/done", 2'h0, {in_ready, sector_done});
    arst_n = 1'b1;
    foreach (rows[k]) run_row(rows[k]);
    // Freeze with ce mid-sector, then a stray start while busy
    fork
      run_row(rows[1]);
      begin
        repeat (40) @(posedge clk_sys);
        #1;
        ce = 1'b0;
        @(posedge clk_sys);
        #1;
        chk_v("frozen ready/valid", 2'h0, {in_ready, out_valid});
        ce = 1'b1;
        sector_start = 1'b1;
        @(posedge clk_sys);
        #1;
        sector_start = 1'b0;
      end
    join
    // Reset mid-head; the next sector must be clean
    sector_start = 1'b1;
    @(posedge clk_sys);
    #1;
    sector_start = 1'b0;
    for (int i = 0; i < 4; i++) put(1'b1, 1'b0, 1'b0, 1'b0);
    arst_n = 1'b0;
    in_valid = 1'b0;
    @(posedge clk_sys);
    #1;
    chk_v("mid reset busy/valid", 2'h0, {busy, out_valid});
    arst_n = 1'b1;
    run_row(rows[2]);
    summarize();
  end
endmodule

`default_nettype wire
